// [rshc_cfg.svh]
// Register offsets, field positions, reset values and timing counts for the reference controller
`ifndef RSHC_CFG_SVH
`define RSHC_CFG_SVH
`define RSHC_OFF_STRAP_OVR   8'h14
`define RSHC_OFF_LOCK_LO     8'h15
`define RSHC_OFF_LOCK_HI     8'h16
`define RSHC_OFF_PLL_LOOP    8'h1c
`define RSHC_OFF_MON_SEL     8'h20
`define RSHC_OFF_SW_MODE     8'h21
`define RSHC_OFF_REVAL       8'h23
`define RSHC_OFF_HO_START    8'h24
`define RSHC_OFF_HO_DIV      8'h25
`define RSHC_OFF_STATUS      8'h26
`define RSHC_OFF_LATCHED     8'h27
`define RSHC_OFF_SLAVE_ADDR  8'h28
// Field positions
`define RSHC_BIT_OVR_MASTER  0
`define RSHC_BIT_TUNE_FORCE  6
`define RSHC_BIT_HO_DIS_N    1
`define RSHC_BIT_EXT_INT     0
`define RSHC_BIT_INT_SEL     4
`define RSHC_BIT_REVERT      5
`define RSHC_BIT_PRIO1       6
`define RSHC_LAT_LOSS0       0
`define RSHC_LAT_LOSS1       1
`define RSHC_LAT_REF         2
`define RSHC_LAT_LOCK        3
// Register reset values and strap decode codes
`define RSHC_RST_LOCK_WINDOW_THRESHOLD     15'h0080
`define RSHC_RST_REVAL       8'h02
`define RSHC_RST_HO_START    8'h10
`define RSHC_RST_HO_DIV      8'h04
`define RSHC_RST_MON_SEL     8'h44
`define RSHC_RST_SW_MODE     8'h00
`define RSHC_RST_PLL_LOOP    8'h10
`define RSHC_ADDR_BASE       5'h1b
`define RSHC_DIV_PECL20      5'h14
`define RSHC_DIV_16          5'h10
// Init sequence length in core cycles
`define RSHC_INIT_CYCLES     8'h20
`endif

// [rshc_pkg.sv]
// Types for the reference select and holdover controller
package rshc_pkg;
  typedef enum logic [1:0] {TRI_LOW, TRI_MID, TRI_HIGH} rshc_tri_t;
  typedef enum logic [1:0] {SW_MANUAL, SW_AUTO, SW_SHORT, SW_AUTO_HO} rshc_mode_t;
  typedef enum logic [1:0] {ST_INIT_IDLE, ST_INIT_RUN, ST_INIT_DONE} rshc_init_t;
endpackage

// [rshc_ctrl.sv]
// Reference select, holdover, lock detect and strap default controller
`timescale 1ns/10ps
`include "rshc_cfg.svh"
//
// Function
// - Reset default: manual holdover, selection from pin
// - Manual change waits for hold-off expiry
// - Manual holdover: flag low, shows new choice
// - Auto loss: holdover, flags low, countdown
// - Revalidation mid-countdown keeps selection, no revert
// - Expiry with revalidated reference: keep, leave
// - Expiry, other valid: switch and leave
// - Expiry, none valid: stay in holdover
// - Write one clears latched flag if gone
// - Expiry on zero transition triggers selection
// - Counter steps on divided clock, start value
// - Counter reloads start value after expiry
// - New loss event only after clear
// - Divider runs only during holdover flows
// - Revert only to higher priority input
// - Revertive off after reset
// - Lock lost when phase exceeds window
// - Profile strap selects bank and init defaults
// - Bank AC strap alone selects type and divide, zeroed on profile low
// - Init starts on profile mid/high, then enable
// - Strap override register stored but unused; slave address from strap
// - Holdover length is start times divider
// - Revalidation needs counted good periods
module rshc_ctrl
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire rshc_pkg::rshc_tri_t profile_strap,
  input  wire rshc_pkg::rshc_tri_t bank_ac_strap,
  input  wire rshc_pkg::rshc_tri_t bank_b_strap,
  input  wire rshc_pkg::rshc_tri_t bank_d_strap,
  input  wire rshc_pkg::rshc_tri_t addr_strap,
  input  wire logic             select_pin,
  input  wire logic [1:0]       signal_lost_event,
  input  wire logic [1:0]       input_good_period,
  input  wire logic             first_pll_tick,
  input  wire logic [14:0]      phase_difference,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  output logic                  selected_input_flag,
  output logic                  not_in_holdover_flag,
  output logic                  reference_valid_now,
  output logic                  first_pll_locked_now,
  output logic [1:0]            input_active_now,
  output logic [6:0]            slave_address,
  output logic [5:0]            bank_config,
  output logic                  outputs_enable
);
  import rshc_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // bank strap decode: bit5 PECL style, low bits divide
  function automatic logic [5:0] bank_dec(input rshc_tri_t s);
    case (s)
      TRI_LOW:  bank_dec = {1'b1, `RSHC_DIV_PECL20};
      TRI_MID:  bank_dec = {1'b0, `RSHC_DIV_16};
      default:  bank_dec = {1'b1, `RSHC_DIV_16};
    endcase
  endfunction

  function automatic logic [1:0] addr_dec(input rshc_tri_t s);
    case (s)
      TRI_LOW:  addr_dec = 2'h0;
      TRI_MID:  addr_dec = 2'h1;
      default:  addr_dec = 2'h3;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  strap_ovr_reg, strap_ovr_next;
  logic [14:0] lock_window_threshold_reg, lock_window_threshold_next;
  logic [7:0]  pll_loop_reg, pll_loop_next;
  logic [7:0]  mon_sel_reg, mon_sel_next;
  logic [7:0]  sw_mode_reg, sw_mode_next;
  logic [7:0]  reval_reg, reval_next;
  logic [7:0]  ho_start_reg, ho_start_next;
  logic [7:0]  ho_div_reg, ho_div_next;
  logic [3:0]  latched_reg, latched_next;
  logic [1:0]  active_reg, active_next;
  logic [1:0]  armed_reg, armed_next;
  logic [7:0]  good_cnt0_reg, good_cnt0_next;
  logic [7:0]  good_cnt1_reg, good_cnt1_next;
  logic        sel_reg, sel_next;
  logic        hold_reg, hold_next;
  logic        nhold_reg, nhold_next;
  logic        refv_reg, refv_next;
  logic        lock_reg, lock_next;
  logic [7:0]  ho_cnt_reg, ho_cnt_next;
  logic [7:0]  div_cnt_reg, div_cnt_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic [6:0]  addr_reg, addr_next;
  logic [5:0]  bank_reg, bank_next;
  logic        oe_reg, oe_next;
  logic        strap_done_reg, strap_done_next;
  rshc_init_t  init_reg, init_next;
  logic [7:0]  init_cnt_reg, init_cnt_next;

  logic        want_sel;
  logic        ho_run;
  logic        ho_tick;
  logic        expire;
  logic        mode_ho_dis_n;
  rshc_mode_t  mode;
  logic [1:0]  revalidated;

  // Register file writes and straps
  always_comb
  begin
    strap_ovr_next  = strap_ovr_reg;
    lock_window_threshold_next    = lock_window_threshold_reg;
    pll_loop_next   = pll_loop_reg;
    mon_sel_next    = mon_sel_reg;
    sw_mode_next    = sw_mode_reg;
    reval_next      = reval_reg;
    ho_start_next   = ho_start_reg;
    ho_div_next     = ho_div_reg;
    addr_next       = addr_reg;
    bank_next       = bank_reg;
    strap_done_next = 1'b1;
    if (!strap_done_reg)
    begin
      addr_next = {`RSHC_ADDR_BASE, addr_dec(addr_strap)};
      bank_next = bank_dec(bank_ac_strap);
      if (profile_strap == TRI_LOW)
        bank_next = 6'h00;
    end
    if (reg_wr)
    begin
      case (reg_addr)
        `RSHC_OFF_STRAP_OVR: strap_ovr_next = reg_wdata;
        `RSHC_OFF_LOCK_LO:   lock_window_threshold_next[7:0] = reg_wdata;
        `RSHC_OFF_LOCK_HI:   lock_window_threshold_next[14:8] = reg_wdata[6:0];
        `RSHC_OFF_PLL_LOOP:  pll_loop_next = reg_wdata;
        `RSHC_OFF_MON_SEL:   mon_sel_next = reg_wdata;
        `RSHC_OFF_SW_MODE:   sw_mode_next = reg_wdata;
        `RSHC_OFF_REVAL:     reval_next = reg_wdata;
        `RSHC_OFF_HO_START:  ho_start_next = reg_wdata;
        `RSHC_OFF_HO_DIV:    ho_div_next = reg_wdata;
        default:             ;
      endcase
    end
  end

  // Mode decode
  always_comb
  begin
    mode_ho_dis_n = mon_sel_reg[`RSHC_BIT_HO_DIS_N];
    mode          = rshc_mode_t'(sw_mode_reg[3:2]);
    // pin or internal bit per source select
    want_sel = mon_sel_reg[`RSHC_BIT_EXT_INT] ? sw_mode_reg[`RSHC_BIT_INT_SEL] : select_pin;
  end

  // ----------------------------------------------------------------
  // Input monitors
  // ----------------------------------------------------------------
  always_comb
  begin
    active_next    = active_reg;
    armed_next     = armed_reg;
    good_cnt0_next = good_cnt0_reg;
    good_cnt1_next = good_cnt1_reg;
    revalidated    = 2'b00;
    for (int i = 0; i < 2; i++)
      if (signal_lost_event[i] && armed_reg[i])
      begin
        active_next[i] = 1'b0;
        armed_next[i]  = 1'b0;
      end
    if (signal_lost_event[0])
      good_cnt0_next = 8'h00;
    else if (!active_reg[0] && input_good_period[0])
    begin
      if (good_cnt0_reg + 8'h01 >= reval_reg)
      begin
        active_next[0] = 1'b1;
        revalidated[0] = 1'b1;
        good_cnt0_next = 8'h00;
      end
      else
        good_cnt0_next = good_cnt0_reg + 8'h01;
    end
    if (signal_lost_event[1])
      good_cnt1_next = 8'h00;
    else if (!active_reg[1] && input_good_period[1])
    begin
      if (good_cnt1_reg + 8'h01 >= reval_reg)
      begin
        active_next[1] = 1'b1;
        revalidated[1] = 1'b1;
        good_cnt1_next = 8'h00;
      end
      else
        good_cnt1_next = good_cnt1_reg + 8'h01;
    end
    // clear of latched loss re-arms the input
    if (reg_wr && reg_addr == `RSHC_OFF_LATCHED)
      for (int i = 0; i < 2; i++)
        if (reg_wdata[i] && active_next[i])
          armed_next[i] = 1'b1;
  end

  // ----------------------------------------------------------------
  // Hold-off divider and counter
  // ----------------------------------------------------------------
  always_comb
  begin
    div_cnt_next = div_cnt_reg;
    ho_tick      = 1'b0;
    ho_run       = hold_reg && (!mode_ho_dis_n || mode == SW_AUTO_HO);
    if (ho_run && first_pll_tick)
    begin
      if (div_cnt_reg + 8'h01 >= ho_div_reg)
      begin
        div_cnt_next = 8'h00;
        ho_tick      = 1'b1;
      end
      else
        div_cnt_next = div_cnt_reg + 8'h01;
    end
    else if (!ho_run)
      div_cnt_next = 8'h00;
    expire = ho_run && ho_tick && (ho_cnt_reg <= 8'h01);
  end

  // ----------------------------------------------------------------
  // Selection and holdover state
  // ----------------------------------------------------------------
  always_comb
  begin
    sel_next     = sel_reg;
    hold_next    = hold_reg;
    refv_next    = refv_reg;
    ho_cnt_next  = ho_cnt_reg;
    latched_next = latched_reg;
    // counter steps down on divided tick
    if (hold_reg && ho_tick && ho_cnt_reg != 8'h00)
      ho_cnt_next = ho_cnt_reg - 8'h01;
    // reload start value on expiry or idle
    if (expire || !hold_reg)
      ho_cnt_next = ho_start_reg;
    if (!mode_ho_dis_n)
    begin
      // holdover flag low, new choice shown
      if (!hold_reg && want_sel != sel_reg)
      begin
        hold_next = 1'b1;
        sel_next  = want_sel;
      end
      else if (expire)
        hold_next = 1'b0;
      refv_next = active_next[sel_next];
    end
    else if (mode == SW_AUTO_HO)
    begin
      if (!hold_reg && !active_next[sel_reg])
      begin
        hold_next = 1'b1;
        refv_next = 1'b0;
      end
      else if (expire)
      begin
        if (active_reg[sel_reg])
        begin
          refv_next = 1'b1;
          hold_next = 1'b0;
        end
        else if (active_reg[!sel_reg])
        begin
          sel_next  = !sel_reg;
          refv_next = 1'b1;
          hold_next = 1'b0;
        end
      end
      // revert only to higher priority input
      else if (!hold_reg && sw_mode_reg[`RSHC_BIT_REVERT]
               && revalidated[!sel_reg]
               && (sw_mode_reg[`RSHC_BIT_PRIO1] == !sel_reg))
        sel_next = !sel_reg;
    end
    else if (mode == SW_AUTO)
    begin
      hold_next = 1'b0;
      if (!active_next[sel_reg] && active_next[!sel_reg])
        sel_next = !sel_reg;
      else if (sw_mode_reg[`RSHC_BIT_REVERT] && revalidated[!sel_reg]
               && (sw_mode_reg[`RSHC_BIT_PRIO1] == !sel_reg))
        sel_next = !sel_reg;
      refv_next = active_next[sel_next];
    end
    else
    begin
      hold_next = (mode == SW_SHORT) && !active_next[sel_reg];
      sel_next  = want_sel;
      refv_next = active_next[sel_next];
    end
    // Latched flags set on condition
    for (int i = 0; i < 2; i++)
      if (!active_next[i])
        latched_next[i] = 1'b1;
    if (!refv_next)
      latched_next[`RSHC_LAT_REF] = 1'b1;
    if (!lock_next)
      latched_next[`RSHC_LAT_LOCK] = 1'b1;
    // clear only once condition has gone
    if (reg_wr && reg_addr == `RSHC_OFF_LATCHED)
    begin
      for (int i = 0; i < 2; i++)
        if (reg_wdata[i] && active_next[i])
          latched_next[i] = 1'b0;
      if (reg_wdata[`RSHC_LAT_REF] && refv_next)
        latched_next[`RSHC_LAT_REF] = 1'b0;
      if (reg_wdata[`RSHC_LAT_LOCK] && lock_next)
        latched_next[`RSHC_LAT_LOCK] = 1'b0;
    end
    // Active-low holdover flag gets its own flop
    nhold_next = !hold_next;
  end

  // ----------------------------------------------------------------
  // Lock detect, init sequence, read data
  // ----------------------------------------------------------------
  always_comb
  begin
    // detector idle while tune force set
    lock_next = pll_loop_reg[`RSHC_BIT_TUNE_FORCE] ? lock_reg
                : (phase_difference <= lock_window_threshold_reg);
    init_next     = init_reg;
    init_cnt_next = init_cnt_reg;
    oe_next       = oe_reg;
    // init on profile mid or high
    case (init_reg)
      ST_INIT_IDLE:
        if (strap_done_reg && profile_strap != TRI_LOW)
          init_next = ST_INIT_RUN;
      ST_INIT_RUN:
        if (init_cnt_reg == `RSHC_INIT_CYCLES)
        begin
          init_next = ST_INIT_DONE;
          oe_next   = 1'b1;
        end
        else
          init_cnt_next = init_cnt_reg + 8'h01;
      ST_INIT_DONE:
        oe_next = 1'b1;
      default:
        init_next = ST_INIT_IDLE;
    endcase
    rdata_next = rdata_reg;
    if (reg_rd)
    begin
      case (reg_addr)
        `RSHC_OFF_STRAP_OVR:  rdata_next = strap_ovr_reg;
        `RSHC_OFF_LOCK_LO:    rdata_next = lock_window_threshold_reg[7:0];
        `RSHC_OFF_LOCK_HI:    rdata_next = {1'b0, lock_window_threshold_reg[14:8]};
        `RSHC_OFF_PLL_LOOP:   rdata_next = pll_loop_reg;
        `RSHC_OFF_MON_SEL:    rdata_next = mon_sel_reg;
        `RSHC_OFF_SW_MODE:    rdata_next = sw_mode_reg;
        `RSHC_OFF_REVAL:      rdata_next = reval_reg;
        `RSHC_OFF_HO_START:   rdata_next = ho_start_reg;
        `RSHC_OFF_HO_DIV:     rdata_next = ho_div_reg;
        `RSHC_OFF_STATUS:     rdata_next = {2'b00, lock_reg, refv_reg, hold_reg ? 1'b0 : 1'b1,
                                            sel_reg, active_reg};
        `RSHC_OFF_LATCHED:    rdata_next = {4'h0, latched_reg};
        `RSHC_OFF_SLAVE_ADDR: rdata_next = {1'b0, addr_reg};
        default:              rdata_next = 8'h00;
      endcase
    end
  end

  // Register all state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_ovr_reg  <= 8'h00;
      lock_window_threshold_reg    <= `RSHC_RST_LOCK_WINDOW_THRESHOLD;
      pll_loop_reg   <= `RSHC_RST_PLL_LOOP;
      mon_sel_reg    <= `RSHC_RST_MON_SEL;
      sw_mode_reg    <= `RSHC_RST_SW_MODE;
      reval_reg      <= `RSHC_RST_REVAL;
      ho_start_reg   <= `RSHC_RST_HO_START;
      ho_div_reg     <= `RSHC_RST_HO_DIV;
      latched_reg    <= 4'h0;
      active_reg     <= 2'b11;
      armed_reg      <= 2'b11;
      good_cnt0_reg  <= 8'h00;
      good_cnt1_reg  <= 8'h00;
      sel_reg        <= 1'b0;
      hold_reg       <= 1'b0;
      nhold_reg      <= 1'b1;
      refv_reg       <= 1'b1;
      lock_reg       <= 1'b0;
      ho_cnt_reg     <= `RSHC_RST_HO_START;
      div_cnt_reg    <= 8'h00;
      rdata_reg      <= 8'h00;
      addr_reg       <= {`RSHC_ADDR_BASE, 2'h0};
      bank_reg       <= 6'h00;
      oe_reg         <= 1'b0;
      strap_done_reg <= 1'b0;
      init_reg       <= ST_INIT_IDLE;
      init_cnt_reg   <= 8'h00;
    end
    else
    begin
      strap_ovr_reg  <= strap_ovr_next;
      lock_window_threshold_reg    <= lock_window_threshold_next;
      pll_loop_reg   <= pll_loop_next;
      mon_sel_reg    <= mon_sel_next;
      sw_mode_reg    <= sw_mode_next;
      reval_reg      <= reval_next;
      ho_start_reg   <= ho_start_next;
      ho_div_reg     <= ho_div_next;
      latched_reg    <= latched_next;
      active_reg     <= active_next;
      armed_reg      <= armed_next;
      good_cnt0_reg  <= good_cnt0_next;
      good_cnt1_reg  <= good_cnt1_next;
      sel_reg        <= sel_next;
      hold_reg       <= hold_next;
      nhold_reg      <= nhold_next;
      refv_reg       <= refv_next;
      lock_reg       <= lock_next;
      ho_cnt_reg     <= ho_cnt_next;
      div_cnt_reg    <= div_cnt_next;
      rdata_reg      <= rdata_next;
      addr_reg       <= addr_next;
      bank_reg       <= bank_next;
      oe_reg         <= oe_next;
      strap_done_reg <= strap_done_next;
      init_reg       <= init_next;
      init_cnt_reg   <= init_cnt_next;
    end
  end

  // Outputs straight from flops
  assign reg_rdata            = rdata_reg;
  assign selected_input_flag  = sel_reg;
  assign not_in_holdover_flag = nhold_reg;
  assign reference_valid_now  = refv_reg;
  assign first_pll_locked_now = lock_reg;
  assign input_active_now     = active_reg;
  assign slave_address        = addr_reg;
  assign bank_config          = bank_reg;
  assign outputs_enable       = oe_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_hold_flag;
    @(posedge clk) disable iff (!reset_n)
      (!mode_ho_dis_n && !hold_reg && want_sel != sel_reg) |=> !not_in_holdover_flag;
  endproperty
  a_hold_flag: assert property (p_hold_flag) else $error("manual change no holdover");

  property p_auto_loss;
    @(posedge clk) disable iff (!reset_n)
      (mode_ho_dis_n && mode == SW_AUTO_HO && !hold_reg && !active_next[sel_reg])
      |=> (!reference_valid_now && hold_reg);
  endproperty
  a_auto_loss: assert property (p_auto_loss) else $error("auto loss not held");

  property p_sel_stable;
    @(posedge clk) disable iff (!reset_n)
      (mode_ho_dis_n && mode == SW_AUTO_HO && hold_reg && hold_next) |=> $stable(sel_reg);
  endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("selection moved in holdover");

  property p_none_valid;
    @(posedge clk) disable iff (!reset_n)
      (mode_ho_dis_n && mode == SW_AUTO_HO && expire && active_reg == 2'b00)
      |=> (hold_reg && !reference_valid_now);
  endproperty
  a_none_valid: assert property (p_none_valid) else $error("left holdover without input");

  property p_clear;
    @(posedge clk) disable iff (!reset_n)
      (reg_wr && reg_addr == `RSHC_OFF_LATCHED && reg_wdata[0] && !active_next[0])
      |=> latched_reg[0];
  endproperty
  a_clear: assert property (p_clear) else $error("flag cleared while lost");

  property p_reload;
    @(posedge clk) disable iff (!reset_n) expire |=> (ho_cnt_reg == $past(ho_start_reg));
  endproperty
  a_reload: assert property (p_reload) else $error("no reload after expiry");

  property p_div_idle;
    @(posedge clk) disable iff (!reset_n) !hold_reg |=> (div_cnt_reg == 8'h00);
  endproperty
  a_div_idle: assert property (p_div_idle) else $error("divider ran while idle");

  property p_lock;
    @(posedge clk) disable iff (!reset_n)
      (!pll_loop_reg[`RSHC_BIT_TUNE_FORCE] && phase_difference > lock_window_threshold_reg)
      |=> !first_pll_locked_now;
  endproperty
  a_lock: assert property (p_lock) else $error("lock kept past window");

  c_manual_ho: cover property (@(posedge clk) disable iff (!reset_n) hold_reg ##1 !hold_reg);
  c_auto_sw: cover property (@(posedge clk) disable iff (!reset_n)
                             expire && mode == SW_AUTO_HO ##1 $changed(sel_reg));
  c_init: cover property (@(posedge clk) disable iff (!reset_n) $rose(outputs_enable));
endmodule // rshc_ctrl

// [rshc_host.sv]
// Register host model that configures and polls the controller
`timescale 1ns/10ps
module rshc_host
(
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  // Idle bus at time zero
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // writes of one clear flags, other registers take data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask
  // Read strobe, data taken a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd   = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule // rshc_host

// [test_reference_select_holdover_ctrl.sv]
// Self-checking bench for the reference select and holdover controller
`timescale 1ns/10ps
module test_reference_select_holdover_ctrl;
  import rshc_pkg::*;
  logic        clk, reset_n, pin, tick, rd, wr, sel, hold_n, ref_ok, lk, oe;
  logic [1:0]  lost, good, act;
  logic [14:0] phase;
  logic [7:0]  addr, wdata, rdata, v;
  logic [6:0]  slave;
  logic [5:0]  bank;
  int          num_errors, tests_run, n;
  rshc_tri_t   prof;
  // Clock and reset
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  rshc_ctrl dut (.clk(clk), .reset_n(reset_n), .profile_strap(prof),
    .bank_ac_strap(TRI_MID), .bank_b_strap(TRI_LOW), .bank_d_strap(TRI_HIGH),
    .addr_strap(TRI_HIGH), .select_pin(pin), .signal_lost_event(lost),
    .input_good_period(good), .first_pll_tick(tick), .phase_difference(phase),
    .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .selected_input_flag(sel), .not_in_holdover_flag(hold_n),
    .reference_valid_now(ref_ok), .first_pll_locked_now(lk),
    .input_active_now(act), .slave_address(slave), .bank_config(bank),
    .outputs_enable(oe));
  rshc_host host (.clk(clk), .reg_rdata(rdata), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wdata));
  // Compare and report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Wait for holdover to end, counting cycles
  task automatic wait_leave();
    n = 0;
    while (hold_n !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  //----------------------------------------
  // Scenarios
  //----------------------------------------
  task automatic t_reset();
    repeat (40) @(negedge clk);
    chk({1'b0, slave}, 8'h6f, "address");
    chk({2'b0, bank}, 8'h10, "bank");
    chk({7'b0, oe}, 8'h01, "enable");
    host.rd(8'h26, v);
    chk(v & 8'h1f, 8'h1b, "status");
    host.rd(8'h21, v);
    chk(v & 8'h20, 8'h00, "revert");
    host.rd(8'h40, v);
    chk(v, 8'h00, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_lock();
    host.wr(8'h1c, 8'h10);
    phase = 15'h0081;
    repeat (3) @(negedge clk);
    chk({7'b0, lk}, 8'h00, "lock lost");
    host.wr(8'h27, 8'h08);
    host.rd(8'h27, v);
    chk(v & 8'h08, 8'h08, "lock clear refused");
    phase = 15'h0080;
    repeat (3) @(negedge clk);
    chk({7'b0, lk}, 8'h01, "lock back");
    host.wr(8'h27, 8'h08);
    host.rd(8'h27, v);
    chk(v & 8'h08, 8'h00, "lock clear");
    $display("test lock done");
  endtask
  task automatic t_manual();
    host.wr(8'h24, 8'h02);
    host.wr(8'h25, 8'h02);
    pin = 1'b1;
    repeat (2) @(negedge clk);
    chk({7'b0, hold_n}, 8'h00, "manual hold");
    chk({7'b0, sel}, 8'h01, "new choice");
    tick = 1'b1;
    wait_leave();
    tick = 1'b0;
    chk({7'b0, hold_n}, 8'h01, "expiry");
    chk({7'b0, (n >= 4 && n <= 6)}, 8'h01, "length");
    $display("test manual done");
  endtask
  task automatic t_auto();
    host.wr(8'h20, 8'h46);
    host.wr(8'h21, 8'h0c);
    lost = 2'b10;
    @(negedge clk);
    lost = 2'b00;
    @(negedge clk);
    chk({6'b0, ref_ok, hold_n}, 8'h00, "loss");
    tick = 1'b1;
    wait_leave();
    tick = 1'b0;
    chk({6'b0, sel, ref_ok}, 8'h01, "failover");
    host.rd(8'h27, v);
    chk(v & 8'h06, 8'h06, "latched");
    host.wr(8'h27, 8'h06);
    host.rd(8'h27, v);
    chk(v & 8'h06, 8'h02, "clear");
    $display("test auto done");
  endtask
  task automatic t_reval();
    good = 2'b10;
    @(negedge clk);
    chk({6'b0, act}, 8'h01, "one period");
    @(negedge clk);
    good = 2'b00;
    chk({6'b0, act}, 8'h03, "revalidated");
    chk({7'b0, sel}, 8'h00, "no revert");
    lost = 2'b10;
    @(negedge clk);
    lost = 2'b00;
    chk({6'b0, act}, 8'h03, "loss not armed");
    host.wr(8'h27, 8'h02);
    host.rd(8'h27, v);
    chk(v & 8'h02, 8'h00, "loss cleared");
    lost = 2'b10;
    @(negedge clk);
    lost = 2'b00;
    chk({6'b0, act}, 8'h01, "loss armed");
    host.wr(8'h21, 8'h6c);
    good = 2'b10;
    repeat (2) @(negedge clk);
    good = 2'b00;
    @(negedge clk);
    chk({7'b0, sel}, 8'h01, "revert to priority");
    $display("test revalidation done");
  endtask
  task automatic t_hold();
    host.wr(8'h27, 8'h02);
    lost = 2'b11;
    @(negedge clk);
    lost = 2'b00;
    tick = 1'b1;
    repeat (6) @(negedge clk);
    tick = 1'b0;
    chk({5'b0, sel, ref_ok, hold_n}, 8'h04, "none valid");
    host.wr(8'h27, 8'h04);
    host.rd(8'h27, v);
    chk(v & 8'h04, 8'h04, "ref clear refused");
    good = 2'b10;
    repeat (2) @(negedge clk);
    good = 2'b00;
    chk({5'b0, act, hold_n}, 8'h04, "reval in countdown");
    chk({7'b0, sel}, 8'h01, "selection kept");
    tick = 1'b1;
    wait_leave();
    tick = 1'b0;
    chk({5'b0, sel, ref_ok, hold_n}, 8'h07, "keep revalidated");
    $display("test holdover done");
  endtask
  task automatic t_strap();
    prof = TRI_LOW;
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (40) @(negedge clk);
    chk({2'b0, bank}, 8'h00, "bank off");
    chk({7'b0, oe}, 8'h00, "no init");
    chk({1'b0, slave}, 8'h6f, "address kept");
    $display("test strap done");
  endtask
  // Main sequence and watchdog
  initial
  begin
    {reset_n, pin, tick, lost, good, phase, num_errors, tests_run} = '0;
    prof = TRI_MID;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_lock();
    t_manual();
    t_auto();
    t_reval();
    t_hold();
    t_strap();
    end_of_test();
  end
  initial
  begin
    #(25 * 3000);
    num_errors++;
    end_of_test();
  end
endmodule // test_reference_select_holdover_ctrl
